// ### design/analog_output_diag_record.sv
// Diagnostic record and output area of the four-channel analog output module
`timescale 1ns/10ps
`include "aio_diag_regs.svh"
module analog_output_diag_record (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic rec_rd,
    input wire aio_diag_pkg::rec_index_t rec_index,
    input wire logic rec_busy,
    output aio_diag_pkg::rec_byte_t rec_data,
    output logic rec_ack,
    input wire logic out_wr,
    input wire aio_diag_pkg::out_addr_t out_addr,
    input wire aio_diag_pkg::ao_word_t out_wdata,
    output logic out_ack,
    output logic out_refused,
    input wire aio_diag_pkg::ch_mask_t wire_break_en,
    input wire aio_diag_pkg::ch_mask_t param_err_pin,
    input wire aio_diag_pkg::ch_mask_t wire_break_pin,
    input wire logic buf_overflow_pin,
    input wire logic comm_err_pin,
    output aio_diag_pkg::ao_word_t output_value_ch0,
    output aio_diag_pkg::ao_word_t output_value_ch1,
    output aio_diag_pkg::ao_word_t output_value_ch2,
    output aio_diag_pkg::ao_word_t output_value_ch3,
    output logic diag_active
);
    import aio_diag_pkg::*;

    // ----------------------------------------
    // Pin conditioning and time base
    // ----------------------------------------
    logic [9:0] pins_raw;
    logic [9:0] pins_level;
    ch_mask_t param_err;
    ch_mask_t wire_break;
    logic buf_overflow;
    logic comm_err;
    tick_t tick_now;

    assign pins_raw = {comm_err_pin, buf_overflow_pin, wire_break_pin, param_err_pin};
    assign param_err = pins_level[3:0];
    assign wire_break = pins_level[7:4];
    assign buf_overflow = pins_level[8];
    assign comm_err = pins_level[9];

    pin_sync #(
        .WIDTH(10)
    ) pin_sync_i (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .pin_in(pins_raw),
        .level_out(pins_level)
    );

    us_tick_counter us_tick_counter_i (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .tick_count(tick_now)
    );

    // ----------------------------------------
    // Error bytes
    // ----------------------------------------
    ch_mask_t wbrk_seen;
    ch_mask_t group_err;
    rec_byte_t detail [4];
    rec_byte_t group_summary;
    rec_byte_t ext_diag;
    rec_byte_t gen_diag;
    rec_byte_t mod_info;
    rec_byte_t ch_kind;
    logic any_err;

    genvar c;
    generate
        for (c = 0; c < 4; c++) begin : g_chan
            always_comb begin
                wbrk_seen[c] = wire_break[c] & wire_break_en[c];
                detail[c] = `BYTE_RESET;
                detail[c][`DETAIL_PARAM_BIT] = param_err[c];
                detail[c][`DETAIL_WBRK_BIT] = wbrk_seen[c];
                group_err[c] = param_err[c] | wbrk_seen[c];
            end
        end
    endgenerate

    always_comb begin
        group_summary = {4'h0, group_err};
        ext_diag = `BYTE_RESET;
        ext_diag[`EXT_OVERFLOW_BIT] = buf_overflow;
        ext_diag[`EXT_COMM_ERR_BIT] = comm_err;
        gen_diag = `BYTE_RESET;
        gen_diag[`GEN_INTERNAL_BIT] = buf_overflow | comm_err;
        gen_diag[`GEN_CHANNEL_BIT] = |group_err;
        gen_diag[`GEN_PARAM_BIT] = |param_err;
        mod_info = `BYTE_RESET;
        mod_info[3:0] = `MOD_CLASS_ANALOG;
        mod_info[`MOD_INFO_CHPRES_BIT] = 1'b1;
        ch_kind = {1'b0, `KIND_ANALOG_OUT};
        any_err = |gen_diag;
    end

    // ----------------------------------------
    // Timestamp capture
    // ----------------------------------------
    tick_t ts_shadow;
    tick_t ts_shown;
    logic any_err_q;
    tick_t next_ts_shadow;
    tick_t next_ts_shown;
    logic diag_event;

    always_comb begin
        diag_event = any_err & ~any_err_q;
        next_ts_shadow = diag_event ? tick_now : ts_shadow;
        if (rec_busy) begin
            next_ts_shown = ts_shown;
        end else begin
            next_ts_shown = next_ts_shadow;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ts_shadow <= `TICK_RESET;
            ts_shown <= `TICK_RESET;
            any_err_q <= 1'b0;
            diag_active <= 1'b0;
        end else begin
            ts_shadow <= next_ts_shadow;
            ts_shown <= next_ts_shown;
            any_err_q <= any_err;
            diag_active <= any_err;
        end
    end

    // ----------------------------------------
    // Record read port
    // ----------------------------------------
    rec_byte_t rd_byte;
    rec_byte_t next_rec_data;
    logic next_rec_ack;

    always_comb begin
        rd_byte = `BYTE_RESET;
        unique case (rec_index)
            `REC_GEN_DIAG: rd_byte = gen_diag;
            `REC_MOD_INFO: rd_byte = mod_info;
            `REC_EXT_DIAG: rd_byte = ext_diag;
            `REC_CH_KIND: rd_byte = ch_kind;
            `REC_DIAG_BITS: rd_byte = `DIAG_BITS_VALUE;
            `REC_CH_COUNT: rd_byte = `CH_COUNT_VALUE;
            `REC_GRP_SUMMARY: rd_byte = group_summary;
            `REC_CH0_DETAIL: rd_byte = detail[0];
            `REC_CH1_DETAIL: rd_byte = detail[1];
            `REC_CH2_DETAIL: rd_byte = detail[2];
            `REC_CH3_DETAIL: rd_byte = detail[3];
            `REC_TS_BYTE0: rd_byte = ts_shown[7:0];
            `REC_TS_BYTE1: rd_byte = ts_shown[15:8];
            `REC_TS_BYTE2: rd_byte = ts_shown[23:16];
            `REC_TS_BYTE3: rd_byte = ts_shown[31:24];
            default: rd_byte = `BYTE_RESET;
        endcase
        next_rec_data = rec_rd ? rd_byte : rec_data;
        next_rec_ack = rec_rd;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            rec_data <= `BYTE_RESET;
            rec_ack <= 1'b0;
        end else begin
            rec_data <= next_rec_data;
            rec_ack <= next_rec_ack;
        end
    end

    // ----------------------------------------
    // Output area write port
    // ----------------------------------------
    // Output area only, nothing returned as process input
    ao_word_t ao_value [4];
    ao_word_t next_ao_value [4];
    logic wr_ok;
    logic next_out_ack;
    logic next_out_refused;

    // Word per channel at even offsets
    assign wr_ok = out_wr & ~out_addr[0];

    generate
        for (c = 0; c < 4; c++) begin : g_ao
            always_comb begin
                if (wr_ok && (out_addr[2:1] == 2'(c))) begin
                    next_ao_value[c] = out_wdata;
                end else begin
                    next_ao_value[c] = ao_value[c];
                end
            end
        end
    endgenerate

    always_comb begin
        next_out_ack = wr_ok;
        next_out_refused = out_wr & out_addr[0];
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < 4; i++) begin
                ao_value[i] <= `OUT_VALUE_RESET;
            end
            out_ack <= 1'b0;
            out_refused <= 1'b0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                ao_value[i] <= next_ao_value[i];
            end
            out_ack <= next_out_ack;
            out_refused <= next_out_refused;
        end
    end

    assign output_value_ch0 = ao_value[0];
    assign output_value_ch1 = ao_value[1];
    assign output_value_ch2 = ao_value[2];
    assign output_value_ch3 = ao_value[3];
endmodule

// ### design/aio_diag_regs.svh
// Offsets, field positions, reset values and timing counts of the diagnostic record
`ifndef AIO_DIAG_REGS_SVH
`define AIO_DIAG_REGS_SVH

// ----------------------------------------
// Record byte offsets
// ----------------------------------------
`define REC_GEN_DIAG 5'h00
`define REC_MOD_INFO 5'h01
`define REC_RSVD_C 5'h02
`define REC_EXT_DIAG 5'h03
`define REC_CH_KIND 5'h04
`define REC_DIAG_BITS 5'h05
`define REC_CH_COUNT 5'h06
`define REC_GRP_SUMMARY 5'h07
`define REC_CH0_DETAIL 5'h08
`define REC_CH1_DETAIL 5'h09
`define REC_CH2_DETAIL 5'h0A
`define REC_CH3_DETAIL 5'h0B
`define REC_TS_BYTE0 5'h10
`define REC_TS_BYTE1 5'h11
`define REC_TS_BYTE2 5'h12
`define REC_TS_BYTE3 5'h13

// ----------------------------------------
// Field positions and constant values
// ----------------------------------------
`define MOD_CLASS_ANALOG 4'h5
`define MOD_INFO_CHPRES_BIT 4
`define EXT_OVERFLOW_BIT 3
`define EXT_COMM_ERR_BIT 4
`define GEN_INTERNAL_BIT 1
`define GEN_CHANNEL_BIT 3
`define GEN_PARAM_BIT 7
`define KIND_DIGITAL_IN 7'h70
`define KIND_ANALOG_IN 7'h71
`define KIND_DIGITAL_OUT 7'h72
`define KIND_ANALOG_OUT 7'h73
`define KIND_ANALOG_INOUT 7'h74
`define KIND_COUNTER 7'h76
`define DIAG_BITS_VALUE 8'h08
`define CH_COUNT_VALUE 8'h04
`define DETAIL_PARAM_BIT 0
`define DETAIL_WBRK_BIT 4

// ----------------------------------------
// Output area and reset values
// ----------------------------------------
`define OUT_CH0 3'h0
`define OUT_CH1 3'h2
`define OUT_CH2 3'h4
`define OUT_CH3 3'h6
`define OUT_VALUE_RESET 16'h0000
`define BYTE_RESET 8'h00
`define TICK_RESET 32'h00000000

// ----------------------------------------
// Timing
// ----------------------------------------
`define TICK_PERIOD_NS 1000
`define REF_CLK_PERIOD_NS 25
`define TICK_CYCLES (`TICK_PERIOD_NS / `REF_CLK_PERIOD_NS)

`endif

// ### design/aio_diag_pkg.sv
// Types shared by the diagnostic record design
package aio_diag_pkg;
    typedef logic [7:0] rec_byte_t;
    typedef logic [4:0] rec_index_t;
    typedef logic [15:0] ao_word_t;
    typedef logic [2:0] out_addr_t;
    typedef logic [31:0] tick_t;
    typedef logic [3:0] ch_mask_t;
endpackage

// ### design/pin_sync.sv
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_level;

    // ----------------------------------------
    // Per-bit filter
    // ----------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_comb begin
                next_level[i] = (stage2[i] == stage3[i]) ? stage3[i] : level_out[i];
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            stage1 <= '0;
            stage2 <= '0;
            stage3 <= '0;
            level_out <= '0;
        end else begin
            stage1 <= pin_in;
            stage2 <= stage1;
            stage3 <= stage2;
            level_out <= next_level;
        end
    end
endmodule

// ### design/us_tick_counter.sv
// Free-running 32-bit microsecond counter
`timescale 1ns/10ps
`include "aio_diag_regs.svh"
module us_tick_counter (
    input wire logic ref_clk,
    input wire logic rst_b,
    output aio_diag_pkg::tick_t tick_count
);
    import aio_diag_pkg::*;

    localparam int DIV_LAST = `TICK_CYCLES - 1;

    logic [5:0] div_cnt;
    logic [5:0] next_div_cnt;
    logic us_en;
    tick_t next_tick_count;

    // ----------------------------------------
    // Microsecond enable and count
    // ----------------------------------------
    always_comb begin
        us_en = (div_cnt == 6'(DIV_LAST));
        next_div_cnt = us_en ? 6'h00 : div_cnt + 6'h01;
        next_tick_count = us_en ? tick_count + 32'h00000001 : tick_count;
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt <= 6'h00;
            tick_count <= `TICK_RESET;
        end else begin
            div_cnt <= next_div_cnt;
            tick_count <= next_tick_count;
        end
    end
endmodule

// ### verification/aio_diag_sva.sv
// Port assertions for the diagnostic record
`timescale 1ns/10ps
module aio_diag_sva (
    input wire logic ref_clk,
    input wire logic rst_b,
    input wire logic rec_rd,
    input wire aio_diag_pkg::rec_index_t rec_index,
    input wire aio_diag_pkg::rec_byte_t rec_data,
    input wire logic rec_ack,
    input wire logic out_wr,
    input wire aio_diag_pkg::out_addr_t out_addr,
    input wire aio_diag_pkg::ao_word_t out_wdata,
    input wire logic out_ack,
    input wire logic out_refused,
    input wire aio_diag_pkg::ao_word_t output_value_ch0,
    input wire aio_diag_pkg::ao_word_t output_value_ch2
);
    import aio_diag_pkg::*;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    sequence rd_at(logic [4:0] i);
        rec_rd && rec_index == i;
    endsequence
    sequence answer(logic [7:0] v);
        rec_ack && rec_data == v;
    endsequence
    class_info_a: assert property (rd_at(5'h01) |=> answer(8'h15))
        else $error("module info byte wrong");
    kind_code_a: assert property (rd_at(5'h04) |=> answer(8'h73))
        else $error("channel kind byte wrong");
    diag_bits_a: assert property (rd_at(5'h05) |=> answer(8'h08))
        else $error("diag bit count wrong");
    chan_count_a: assert property (rd_at(5'h06) |=> answer(8'h04))
        else $error("channel count wrong");
    ext_reserved_a: assert property (rd_at(5'h03) |=> (rec_data & 8'hE7) == 8'h00)
        else $error("ext diag reserved bits set");
    gen_reserved_a: assert property (rd_at(5'h00) |=> (rec_data & 8'h60) == 8'h00)
        else $error("general diag reserved bits set");
    summary_rsvd_a: assert property (rd_at(5'h07) |=> rec_data[7:4] == 4'h0)
        else $error("summary reserved bits set");
    detail_rsvd_a: assert property (rec_rd && rec_index[4:2] == 3'b010 |=>
        (rec_data & 8'hEE) == 8'h00) else $error("detail reserved bits set");
    ack_source_a: assert property (rec_ack |-> $past(rec_rd))
        else $error("record ack without read");
    even_write_a: assert property (out_wr && out_addr == 3'h4 |=> out_ack &&
        !out_refused && output_value_ch2 == $past(out_wdata)) else $error("ch2 write lost");
    odd_refuse_a: assert property (out_wr && out_addr[0] |=> out_refused &&
        !out_ack && $stable(output_value_ch0)) else $error("odd write not refused");
endmodule
bind analog_output_diag_record aio_diag_sva aio_diag_sva_i (.ref_clk, .rst_b, .rec_rd,
    .rec_index, .rec_data, .rec_ack, .out_wr, .out_addr, .out_wdata, .out_ack,
    .out_refused, .output_value_ch0, .output_value_ch2);

// ### verification/host_model.sv
// Backplane host model: record reads and output-area writes
`timescale 1ns/10ps
module host_model (
    input wire logic ref_clk,
    output logic rec_rd,
    output aio_diag_pkg::rec_index_t rec_index,
    input wire aio_diag_pkg::rec_byte_t rec_data,
    input wire logic rec_ack,
    output logic out_wr,
    output aio_diag_pkg::out_addr_t out_addr,
    output aio_diag_pkg::ao_word_t out_wdata,
    input wire logic out_ack,
    input wire logic out_refused
);
    import aio_diag_pkg::*;
    initial begin
        rec_rd = 1'b0;
        rec_index = 5'h1F;
        out_wr = 1'b0;
        out_addr = 3'h7;
        out_wdata = 16'hFFFF;
    end
    // Idle lines show inverted last value
    task rd(input rec_index_t idx, output rec_byte_t d, output logic ack);
        @(negedge ref_clk);
        rec_rd = 1'b1;
        rec_index = idx;
        @(negedge ref_clk);
        d = rec_data;
        ack = rec_ack;
        rec_rd = 1'b0;
        rec_index = ~idx;
    endtask
    task wr(input out_addr_t a, input ao_word_t v, output logic ack, output logic rf);
        @(negedge ref_clk);
        out_wr = 1'b1;
        out_addr = a;
        out_wdata = v;
        @(negedge ref_clk);
        ack = out_ack;
        rf = out_refused;
        out_wr = 1'b0;
        out_addr = ~a;
        out_wdata = ~v;
    endtask
endmodule

// ### verification/analog_output_diag_record_tb.sv
// Self-checking bench for the diagnostic record
`timescale 1ns/10ps
module analog_output_diag_record_tb;
    import aio_diag_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic rec_busy = 1'b0;
    ch_mask_t wire_break_en = 4'h0;
    ch_mask_t param_err_pin = 4'h0;
    ch_mask_t wire_break_pin = 4'h0;
    logic buf_overflow_pin = 1'b0;
    logic comm_err_pin = 1'b0;
    logic rec_rd, rec_ack, out_wr, out_ack, out_refused, diag_active, a, r;
    rec_index_t rec_index;
    rec_byte_t rec_data, d;
    out_addr_t out_addr;
    ao_word_t out_wdata, output_value_ch0, output_value_ch1, output_value_ch2, output_value_ch3;
    ao_word_t ov [4];
    tick_t ts0, ts1;
    int miscompares = 0;
    int check_count = 0;
    int cyc = 0;
    int c0;
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (rst_b) cyc++;
    always_comb ov = '{output_value_ch0, output_value_ch1, output_value_ch2, output_value_ch3};
    analog_output_diag_record analog_output_diag_record_i (.ref_clk, .rst_b, .rec_rd,
        .rec_index, .rec_busy, .rec_data, .rec_ack, .out_wr, .out_addr, .out_wdata,
        .out_ack, .out_refused, .wire_break_en, .param_err_pin, .wire_break_pin,
        .buf_overflow_pin, .comm_err_pin, .output_value_ch0, .output_value_ch1,
        .output_value_ch2, .output_value_ch3, .diag_active);
    host_model host_model_i (.ref_clk, .rec_rd, .rec_index, .rec_data, .rec_ack, .out_wr,
        .out_addr, .out_wdata, .out_ack, .out_refused);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task rdc(input rec_index_t idx, input rec_byte_t exp);
        host_model_i.rd(idx, d, a);
        chk(a, 1'b1);
        chk(d, exp);
    endtask
    task wt(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    task rts(output tick_t t);
        for (int k = 0; k < 4; k++) begin
            host_model_i.rd(5'h10 + k[4:0], d, a);
            t[8*k+:8] = d;
        end
    endtask
    task t_consts;
        rdc(5'h01, 8'h15);
        rdc(5'h04, 8'h73);
        rdc(5'h05, 8'h08);
        rdc(5'h06, 8'h04);
        rdc(5'h02, 8'h00);
        rdc(5'h0C, 8'h00);
        rdc(5'h1F, 8'h00);
        rdc(5'h07, 8'h00);
        rdc(5'h13, 8'h00);
    endtask
    task t_writes;
        for (int i = 0; i < 4; i++) begin
            host_model_i.wr(3'(2 * i), 16'hA000 + 16'(i), a, r);
            chk({a, r}, 2'b10);
            chk(ov[i], 16'hA000 + 16'(i));
        end
        host_model_i.wr(3'h5, 16'h5555, a, r);
        chk({a, r}, 2'b01);
        chk(ov[2], 16'hA002);
    endtask
    task t_reset;
        rst_b = 1'b0;
        wt(2);
        rst_b = 1'b1;
        wt(1);
        for (int i = 0; i < 4; i++) begin
            chk(ov[i], 16'h0000);
        end
        rts(ts0);
        chk(ts0, 32'h00000000);
    endtask
    task t_errors;
        wire_break_en = 4'hF;
        param_err_pin = 4'h2;
        wire_break_pin = 4'h4;
        wt(8);
        rdc(5'h08, 8'h00);
        rdc(5'h09, 8'h01);
        rdc(5'h0A, 8'h10);
        rdc(5'h07, 8'h06);
        rdc(5'h00, 8'h88);
        chk(diag_active, 1'b1);
        wire_break_en = 4'hB;
        param_err_pin = 4'h0;
        buf_overflow_pin = 1'b1;
        wt(8);
        rdc(5'h0A, 8'h00);
        rdc(5'h07, 8'h00);
        rdc(5'h03, 8'h08);
        comm_err_pin = 1'b1;
        wt(8);
        rdc(5'h03, 8'h18);
        rdc(5'h00, 8'h02);
        buf_overflow_pin = 1'b0;
        comm_err_pin = 1'b0;
        wire_break_pin = 4'h0;
        wt(8);
        chk(diag_active, 1'b0);
    endtask
    task t_stamp;
        wt(400);
        c0 = cyc;
        comm_err_pin = 1'b1;
        wt(10);
        rec_busy = 1'b1;
        rts(ts0);
        chk(ts0 >= (c0 - 1) / 40 && ts0 <= (c0 + 8) / 40, 1'b1);
        comm_err_pin = 1'b0;
        wt(60);
        comm_err_pin = 1'b1;
        wt(10);
        rts(ts1);
        chk(ts1, ts0);
        rec_busy = 1'b0;
        wt(3);
        rts(ts1);
        chk(ts1 > ts0, 1'b1);
        comm_err_pin = 1'b0;
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge ref_clk);
        wt(1);
        rst_b = 1'b1;
        t_consts;
        t_writes;
        t_errors;
        t_stamp;
        t_reset;
        tally_and_finish;
    end
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares++;
        tally_and_finish;
    end
endmodule
